// >>> shared/protection_switchover_pkg.sv
package protection_switchover_pkg;

   // ==========================================================
   // clock and retry timing
   localparam int CLK_PERIOD_NS = 5;
   // retry period of each timer, in ns; plain defaults, tune per system
   localparam int STD_RETRY_NS = 10000;
   localparam int FORCED_RETRY_NS = 10000;
   localparam int REQ_RETRY_NS = 10000;
   localparam int TMR_W = 12;
   // a least time rounds up to whole cycles
   localparam logic [TMR_W-1:0] STD_RETRY_CYC =
      TMR_W'((STD_RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] FORCED_RETRY_CYC =
      TMR_W'((FORCED_RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] REQ_RETRY_CYC =
      TMR_W'((REQ_RETRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [TMR_W-1:0] TMR_ONE = 12'h001;

   // ==========================================================
   // message field widths
   localparam int LCC_W = 16;
   localparam int LINK_W = 8;
   localparam int TS_W = 5;
   localparam int CAUSE_W = 8;
   localparam logic [LINK_W-1:0] LINK_NONE = 8'h00;
   localparam logic [TS_W-1:0] TS_NONE = 5'h00;
   localparam logic [LCC_W-1:0] LCC_NONE = 16'h0000;
   localparam logic [CAUSE_W-1:0] CAUSE_NONE = 8'h00;
   // cause codes: plain defaults, set to the system's code points
   localparam logic [CAUSE_W-1:0] CAUSE_TARGET_BUSY = 8'h01;
   localparam logic [CAUSE_W-1:0] CAUSE_NOT_POSSIBLE = 8'h02;

   // ==========================================================
   // states
   typedef enum logic [1:0] {an_idle, an_requested, an_le_initiated} an_state_t;
   typedef enum logic [1:0] {le_idle, le_initiated, le_an_requested} le_state_t;

endpackage

// >>> design/retry_timer.sv
`timescale 1ns/1ps
module retry_timer
   import protection_switchover_pkg::*;
#(
   parameter logic [TMR_W-1:0] CYCLES = STD_RETRY_CYC
) (
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic start,
   input wire logic restart,
   input wire logic stop,
   output logic expire_q,
   output logic second_q
);

   // ==========================================================
   // run and count
   logic run_q;
   logic [TMR_W-1:0] cnt_q;
   logic seen_q;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         run_q <= 1'b0;
         cnt_q <= '0;
      end else if (start || restart) begin
         run_q <= 1'b1;
         cnt_q <= '0;
      end else if (stop) begin
         run_q <= 1'b0;
      end else if (run_q && cnt_q == CYCLES - TMR_ONE) begin
         run_q <= 1'b0;
      end else if (run_q) begin
         cnt_q <= cnt_q + TMR_ONE;
      end
   end

   // ==========================================================
   // expiry pulse and one-bit expiry count
   always_ff @(posedge mclk) begin
      expire_q <= 1'b0;
      second_q <= 1'b0;
      if (!rst_n) begin
         seen_q <= 1'b0;
      end else if (start) begin
         seen_q <= 1'b0;
      end else if (run_q && !restart && !stop && cnt_q == CYCLES - TMR_ONE) begin
         expire_q <= 1'b1;
         second_q <= seen_q;
         seen_q <= 1'b1;
      end
   end

endmodule

// >>> design/protection_switchover_fsm.sv
`timescale 1ns/1ps
module protection_switchover_fsm
   import protection_switchover_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   // AN management primitives
   input wire logic an_mgmt_req,
   input wire logic an_mgmt_oper,
   input wire logic an_mgmt_pref_valid,
   input wire logic [LCC_W-1:0] an_mgmt_lcc,
   input wire logic [LINK_W-1:0] an_mgmt_link,
   input wire logic [TS_W-1:0] an_mgmt_ts,
   input wire logic an_mgmt_ack,
   input wire logic an_mgmt_reject,
   input wire logic [CAUSE_W-1:0] an_mgmt_cause,
   // AN messages from peer
   input wire logic an_rx_com,
   input wire logic an_rx_os_com,
   input wire logic an_rx_reject,
   input wire logic [CAUSE_W-1:0] an_rx_cause,
   // AN messages to peer
   output logic an_tx_req_q,
   output logic an_tx_ack_q,
   output logic an_tx_reject_q,
   output logic [LCC_W-1:0] an_tx_lcc_q,
   output logic [LINK_W-1:0] an_tx_link_q,
   output logic [TS_W-1:0] an_tx_ts_q,
   output logic [CAUSE_W-1:0] an_tx_cause_q,
   // AN indications to management
   output logic an_ind_com_q,
   output logic an_ind_os_com_q,
   output logic an_ind_reject_q,
   output logic an_ind_error_q,
   output logic [CAUSE_W-1:0] an_ind_cause_q,
   output an_state_t an_state_q,
   // LE management primitives
   input wire logic le_mgmt_com,
   input wire logic le_mgmt_os_com,
   input wire logic le_mgmt_reject,
   input wire logic [CAUSE_W-1:0] le_mgmt_cause,
   // LE messages from peer
   input wire logic le_rx_req,
   input wire logic le_rx_ack,
   input wire logic le_rx_reject,
   input wire logic [CAUSE_W-1:0] le_rx_cause,
   // LE messages to peer
   output logic le_tx_com_q,
   output logic le_tx_os_com_q,
   output logic le_tx_reject_q,
   output logic [CAUSE_W-1:0] le_tx_cause_q,
   // LE indications to management
   output logic le_ind_req_q,
   output logic le_ind_ack_q,
   output logic le_ind_reject_q,
   output logic le_ind_error_q,
   output logic [CAUSE_W-1:0] le_ind_cause_q,
   output le_state_t le_state_q
);

   // ==========================================================
   // retry timers
   logic req_start, req_restart, req_stop, req_exp, req_second;
   logic std_start, std_restart, std_stop, std_exp, std_second;
   logic frc_start, frc_restart, frc_stop, frc_exp, frc_second;

   retry_timer #(.CYCLES(REQ_RETRY_CYC)) request_retry_timer (
      .mclk(mclk), .rst_n(rst_n), .start(req_start), .restart(req_restart),
      .stop(req_stop), .expire_q(req_exp), .second_q(req_second)
   );
   retry_timer #(.CYCLES(STD_RETRY_CYC)) std_command_retry_timer (
      .mclk(mclk), .rst_n(rst_n), .start(std_start), .restart(std_restart),
      .stop(std_stop), .expire_q(std_exp), .second_q(std_second)
   );
   retry_timer #(.CYCLES(FORCED_RETRY_CYC)) forced_command_retry_timer (
      .mclk(mclk), .rst_n(rst_n), .start(frc_start), .restart(frc_restart),
      .stop(frc_stop), .expire_q(frc_exp), .second_q(frc_second)
   );

   // ==========================================================
   // AN entity
   an_state_t an_state_d;
   logic an_tx_req_d, an_tx_ack_d, an_tx_reject_d;
   logic an_ind_com_d, an_ind_os_com_d, an_ind_reject_d, an_ind_error_d;
   logic an_forced_q;

   // peer messages take priority over primitives in the same cycle
   always_comb begin
      an_state_d = an_state_q;
      an_tx_req_d = 1'b0;
      an_tx_ack_d = 1'b0;
      an_tx_reject_d = 1'b0;
      an_ind_com_d = 1'b0;
      an_ind_os_com_d = 1'b0;
      an_ind_reject_d = 1'b0;
      an_ind_error_d = 1'b0;
      req_start = 1'b0;
      req_restart = 1'b0;
      req_stop = 1'b0;
      case (an_state_q)
         an_idle: begin
            if (an_rx_com) begin
               an_state_d = an_le_initiated;
               an_ind_com_d = 1'b1;
            end else if (an_rx_os_com) begin
               an_state_d = an_le_initiated;
               an_ind_os_com_d = 1'b1;
            end else if (an_mgmt_req) begin
               an_tx_req_d = 1'b1;
               req_start = 1'b1;
               an_state_d = an_requested;
            end
         end
         an_requested: begin
            if (an_rx_com) begin
               an_state_d = an_le_initiated;
               an_ind_com_d = 1'b1;
               req_stop = 1'b1;
            end else if (an_rx_os_com) begin
               an_state_d = an_le_initiated;
               an_ind_os_com_d = 1'b1;
               req_stop = 1'b1;
            end else if (an_rx_reject) begin
               an_ind_reject_d = 1'b1;
               req_stop = 1'b1;
               an_state_d = an_idle;
            end else if (req_exp && req_second) begin
               an_ind_error_d = 1'b1;
               an_state_d = an_idle;
            end else if (req_exp) begin
               an_tx_req_d = 1'b1;
               req_restart = 1'b1;
            end
         end
         an_le_initiated: begin
            if (an_mgmt_ack) begin
               an_tx_ack_d = 1'b1;
               an_state_d = an_idle;
            end else if (an_mgmt_reject) begin
               an_tx_reject_d = 1'b1;
               an_state_d = an_idle;
            end
         end
         default: an_state_d = an_idle;
      endcase
      // other primitives fall through with no effect
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         an_state_q <= an_idle;
         an_tx_req_q <= 1'b0;
         an_tx_ack_q <= 1'b0;
         an_tx_reject_q <= 1'b0;
         an_ind_com_q <= 1'b0;
         an_ind_os_com_q <= 1'b0;
         an_ind_reject_q <= 1'b0;
         an_ind_error_q <= 1'b0;
      end else begin
         an_state_q <= an_state_d;
         an_tx_req_q <= an_tx_req_d;
         an_tx_ack_q <= an_tx_ack_d;
         an_tx_reject_q <= an_tx_reject_d;
         an_ind_com_q <= an_ind_com_d;
         an_ind_os_com_q <= an_ind_os_com_d;
         an_ind_reject_q <= an_ind_reject_d;
         an_ind_error_q <= an_ind_error_d;
      end
   end

   // request fields are latched once; a resend repeats them unchanged
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         an_tx_lcc_q <= LCC_NONE;
         an_tx_link_q <= LINK_NONE;
         an_tx_ts_q <= TS_NONE;
      end else if (an_state_q == an_idle && an_tx_req_d) begin
         an_tx_lcc_q <= an_mgmt_lcc;
         if (an_mgmt_oper && an_mgmt_pref_valid) begin
            an_tx_link_q <= an_mgmt_link;
            an_tx_ts_q <= an_mgmt_ts;
         end else begin
            an_tx_link_q <= LINK_NONE;
            an_tx_ts_q <= TS_NONE;
         end
      end
   end

   // remembers whether the pending command was the forced one
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         an_forced_q <= 1'b0;
      end else if (an_ind_os_com_d) begin
         an_forced_q <= 1'b1;
      end else if (an_ind_com_d) begin
         an_forced_q <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         an_tx_cause_q <= CAUSE_NONE;
         an_ind_cause_q <= CAUSE_NONE;
      end else begin
         if (an_tx_reject_d) begin
            // forced command may pre-empt, so busy target is no excuse
            if (an_forced_q && an_mgmt_cause == CAUSE_TARGET_BUSY) begin
               an_tx_cause_q <= CAUSE_NOT_POSSIBLE;
            end else begin
               an_tx_cause_q <= an_mgmt_cause;
            end
         end
         if (an_ind_reject_d) begin
            an_ind_cause_q <= an_rx_cause;
         end
      end
   end

   // ==========================================================
   // LE entity
   le_state_t le_state_d;
   logic le_tx_com_d, le_tx_os_com_d, le_tx_reject_d;
   logic le_ind_req_d, le_ind_ack_d, le_ind_reject_d, le_ind_error_d;

   always_comb begin
      le_state_d = le_state_q;
      le_tx_com_d = 1'b0;
      le_tx_os_com_d = 1'b0;
      le_tx_reject_d = 1'b0;
      le_ind_req_d = 1'b0;
      le_ind_ack_d = 1'b0;
      le_ind_reject_d = 1'b0;
      le_ind_error_d = 1'b0;
      std_start = 1'b0;
      std_restart = 1'b0;
      std_stop = 1'b0;
      frc_start = 1'b0;
      frc_restart = 1'b0;
      frc_stop = 1'b0;
      case (le_state_q)
         le_idle: begin
            if (le_rx_req) begin
               le_state_d = le_an_requested;
               le_ind_req_d = 1'b1;
            end else if (le_rx_ack) begin
               le_ind_ack_d = 1'b1;
            end else if (le_rx_reject) begin
               le_ind_reject_d = 1'b1;
            end else if (le_mgmt_com) begin
               le_tx_com_d = 1'b1;
               std_start = 1'b1;
               le_state_d = le_initiated;
            end else if (le_mgmt_os_com) begin
               le_tx_os_com_d = 1'b1;
               frc_start = 1'b1;
               le_state_d = le_initiated;
            end
         end
         le_an_requested: begin
            // forced command is not a legal answer here and is dropped
            if (le_mgmt_com) begin
               le_tx_com_d = 1'b1;
               std_start = 1'b1;
               le_state_d = le_initiated;
            end else if (le_mgmt_reject) begin
               le_tx_reject_d = 1'b1;
               le_state_d = le_idle;
            end
         end
         le_initiated: begin
            if (le_rx_ack) begin
               le_ind_ack_d = 1'b1;
               std_stop = 1'b1;
               frc_stop = 1'b1;
               le_state_d = le_idle;
            end else if (le_rx_reject) begin
               le_ind_reject_d = 1'b1;
               frc_stop = 1'b1;
               std_stop = 1'b1;
               le_state_d = le_idle;
            end else if (le_rx_req) begin
               le_state_d = le_initiated;
            end else if (frc_exp && frc_second) begin
               le_ind_error_d = 1'b1;
               le_state_d = le_idle;
            end else if (frc_exp) begin
               le_tx_os_com_d = 1'b1;
               frc_restart = 1'b1;
            end else if (std_exp && std_second) begin
               le_ind_error_d = 1'b1;
               le_state_d = le_idle;
            end else if (std_exp) begin
               le_tx_com_d = 1'b1;
               std_restart = 1'b1;
            end
         end
         default: le_state_d = le_idle;
      endcase
      // expiries and primitives outside their state do nothing
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         le_state_q <= le_idle;
         le_tx_com_q <= 1'b0;
         le_tx_os_com_q <= 1'b0;
         le_tx_reject_q <= 1'b0;
         le_ind_req_q <= 1'b0;
         le_ind_ack_q <= 1'b0;
         le_ind_reject_q <= 1'b0;
         le_ind_error_q <= 1'b0;
      end else begin
         le_state_q <= le_state_d;
         le_tx_com_q <= le_tx_com_d;
         le_tx_os_com_q <= le_tx_os_com_d;
         le_tx_reject_q <= le_tx_reject_d;
         le_ind_req_q <= le_ind_req_d;
         le_ind_ack_q <= le_ind_ack_d;
         le_ind_reject_q <= le_ind_reject_d;
         le_ind_error_q <= le_ind_error_d;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         le_tx_cause_q <= CAUSE_NONE;
         le_ind_cause_q <= CAUSE_NONE;
      end else begin
         if (le_tx_reject_d) begin
            le_tx_cause_q <= le_mgmt_cause;
         end
         if (le_ind_reject_d) begin
            le_ind_cause_q <= le_rx_cause;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   sequence an_req_taken_s;
      an_state_q == an_idle && an_mgmt_req && !an_rx_com && !an_rx_os_com;
   endsequence
   sequence an_req_sent_s;
      an_tx_req_q && an_state_q == an_requested;
   endsequence

   an_reject_idle_a: assert property (
      an_state_q == an_le_initiated && an_mgmt_reject && !an_mgmt_ack
      |=> an_tx_reject_q && an_state_q == an_idle && an_tx_cause_q != CAUSE_NONE
          || an_tx_reject_q && an_state_q == an_idle && $past(an_mgmt_cause) == CAUSE_NONE)
      else $error("AN reject primitive did not send reject");
   an_forced_cause_a: assert property (
      an_tx_reject_q && an_forced_q |-> an_tx_cause_q != CAUSE_TARGET_BUSY)
      else $error("busy target cause sent against forced command");
   le_forced_reject_a: assert property (
      le_state_q == le_initiated && le_rx_reject && !le_rx_ack
      |=> le_ind_reject_q && le_state_q == le_idle && $past(le_rx_cause) == le_ind_cause_q)
      else $error("LE reject in forced state mishandled");
   le_forced_retry_a: assert property (
      le_state_q == le_initiated && frc_exp && !frc_second
      && !le_rx_ack && !le_rx_reject && !le_rx_req
      |=> le_tx_os_com_q && le_state_q == le_initiated)
      else $error("forced command not resent on first expiry");
   le_forced_error_a: assert property (
      le_state_q == le_initiated && frc_exp && frc_second
      && !le_rx_ack && !le_rx_reject && !le_rx_req
      |=> le_ind_error_q && le_state_q == le_idle)
      else $error("second forced expiry did not end in error");
   an_req_start_a: assert property (
      an_req_taken_s |=> an_req_sent_s)
      else $error("AN request not sent");
   an_no_pref_a: assert property (
      an_tx_req_q && !$past(an_mgmt_oper)
      && $past(an_state_q) == an_idle |-> an_tx_link_q == LINK_NONE
      && an_tx_ts_q == TS_NONE)
      else $error("autonomous request carries a target");
   le_req_discard_a: assert property (
      le_state_q == le_initiated && le_rx_req |=> !le_ind_req_q && le_state_q == le_initiated
      || le_state_q == le_idle)
      else $error("request in LE-initiated state acted on");
   le_ack_done_a: assert property (
      le_state_q == le_initiated && le_rx_ack
      |=> le_ind_ack_q && le_state_q == le_idle ##1 !std_exp [*2])
      else $error("ack in LE-initiated state mishandled");
   an_retry_twice_a: assert property (
      an_state_q == an_requested && req_exp && req_second
      && !an_rx_com && !an_rx_os_com && !an_rx_reject
      |=> an_ind_error_q && an_state_q == an_idle)
      else $error("second request expiry did not end in error");

endmodule

// >>> dv/an_mgmt_model.sv
`timescale 1ns/1ps
module an_mgmt_model
   import protection_switchover_pkg::*;
(
   input wire logic mclk,
   input wire logic ind_com,
   input wire logic ind_os_com,
   input wire logic reject_mode,
   input wire logic [CAUSE_W-1:0] reject_cause,
   output logic ack,
   output logic reject,
   output logic [CAUSE_W-1:0] cause
);
   // ==========================================================
   // answers a command primitive in the very next cycle
   initial begin
      ack = 1'h0;
      reject = 1'h0;
      cause = 8'h00;
   end
   always @(negedge mclk) begin
      ack <= (ind_com | ind_os_com) & ~reject_mode;
      reject <= (ind_com | ind_os_com) & reject_mode;
      // cause only counts with reject, so it churns otherwise
      cause <= (ind_com | ind_os_com) ? reject_cause : ~cause;
   end
endmodule

// >>> dv/protection_switchover_fsm_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin fails++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module protection_switchover_fsm_tb;
   import protection_switchover_pkg::*;
   // ==========================================================
   // stimulus and observed signals
   logic mclk = 1'h0;
   logic rst_n = 1'h0;
   logic an_mgmt_req = 1'h0, an_mgmt_oper = 1'h0, an_mgmt_pref_valid = 1'h0;
   logic [LCC_W-1:0] an_mgmt_lcc = 16'h0000;
   logic [LINK_W-1:0] an_mgmt_link = 8'h00;
   logic [TS_W-1:0] an_mgmt_ts = 5'h00;
   logic an_rx_com = 1'h0, an_rx_os_com = 1'h0, an_rx_reject = 1'h0;
   logic [CAUSE_W-1:0] an_rx_cause = 8'h00, le_mgmt_cause = 8'h00, le_rx_cause = 8'h00;
   logic le_mgmt_com = 1'h0, le_mgmt_os_com = 1'h0, le_mgmt_reject = 1'h0;
   logic le_rx_req = 1'h0, le_rx_ack = 1'h0, le_rx_reject = 1'h0;
   logic rej_mode = 1'h0;
   logic [CAUSE_W-1:0] rej_cause = 8'h00, an_mgmt_cause;
   logic an_mgmt_ack, an_mgmt_reject;
   logic an_tx_req_q, an_tx_ack_q, an_tx_reject_q;
   logic [LCC_W-1:0] an_tx_lcc_q;
   logic [LINK_W-1:0] an_tx_link_q;
   logic [TS_W-1:0] an_tx_ts_q;
   logic [CAUSE_W-1:0] an_tx_cause_q, an_ind_cause_q, le_tx_cause_q, le_ind_cause_q;
   logic an_ind_com_q, an_ind_os_com_q, an_ind_reject_q, an_ind_error_q;
   logic le_tx_com_q, le_tx_os_com_q, le_tx_reject_q;
   logic le_ind_req_q, le_ind_ack_q, le_ind_reject_q, le_ind_error_q;
   an_state_t an_state_q;
   le_state_t le_state_q;
   int fails = 0;
   int num_checks = 0;
   int cyc = 0;

   protection_switchover_fsm dut (
      .mclk, .rst_n, .an_mgmt_req, .an_mgmt_oper, .an_mgmt_pref_valid, .an_mgmt_lcc,
      .an_mgmt_link, .an_mgmt_ts, .an_mgmt_ack, .an_mgmt_reject, .an_mgmt_cause,
      .an_rx_com, .an_rx_os_com, .an_rx_reject, .an_rx_cause, .an_tx_req_q, .an_tx_ack_q,
      .an_tx_reject_q, .an_tx_lcc_q, .an_tx_link_q, .an_tx_ts_q, .an_tx_cause_q,
      .an_ind_com_q, .an_ind_os_com_q, .an_ind_reject_q, .an_ind_error_q, .an_ind_cause_q,
      .an_state_q, .le_mgmt_com, .le_mgmt_os_com, .le_mgmt_reject, .le_mgmt_cause,
      .le_rx_req, .le_rx_ack, .le_rx_reject, .le_rx_cause, .le_tx_com_q, .le_tx_os_com_q,
      .le_tx_reject_q, .le_tx_cause_q, .le_ind_req_q, .le_ind_ack_q, .le_ind_reject_q,
      .le_ind_error_q, .le_ind_cause_q, .le_state_q
   );

   an_mgmt_model peer (
      .mclk(mclk), .ind_com(an_ind_com_q), .ind_os_com(an_ind_os_com_q),
      .reject_mode(rej_mode), .reject_cause(rej_cause), .ack(an_mgmt_ack),
      .reject(an_mgmt_reject), .cause(an_mgmt_cause)
   );

   // ==========================================================
   // clock, timeout and verdict
   always #(CLK_PERIOD_NS / 2.0) mclk = ~mclk;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // all scenarios together take some 20500 cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails++;
         end_sim();
      end
   end

   // ==========================================================
   // helpers: inputs change only at the falling edge
   task automatic step();
      @(negedge mclk);
   endtask

   // no retry or error pulse may show for n cycles
   task automatic quiet(input int n);
      logic any;
      any = 1'h0;
      repeat (n) begin
         step();
         any |= an_tx_req_q | an_ind_error_q | le_tx_com_q | le_tx_os_com_q | le_ind_error_q;
      end
      `CHK("retry pulses", 1'h0, any)
   endtask

   // ==========================================================
   // scenarios
   task automatic t_an_oper_ack();
      an_mgmt_oper = 1'h1;
      an_mgmt_pref_valid = 1'h1;
      an_mgmt_lcc = 16'h1234;
      an_mgmt_link = 8'h5a;
      an_mgmt_ts = 5'h13;
      an_mgmt_req = 1'h1;
      step();
      an_mgmt_req = 1'h0;
      an_mgmt_lcc = 16'hffff;
      `CHK("an_tx_req", 1'h1, an_tx_req_q)
      `CHK("an_state", an_requested, an_state_q)
      `CHK("an_tx_lcc", 16'h1234, an_tx_lcc_q)
      `CHK("an_tx_link", 8'h5a, an_tx_link_q)
      `CHK("an_tx_ts", 5'h13, an_tx_ts_q)
      an_rx_com = 1'h1;
      step();
      an_rx_com = 1'h0;
      `CHK("an_ind_com", 1'h1, an_ind_com_q)
      `CHK("an_state", an_le_initiated, an_state_q)
      step();
      `CHK("an_tx_ack", 1'h1, an_tx_ack_q)
      `CHK("an_state", an_idle, an_state_q)
      quiet(2100);
   endtask

   task automatic t_an_auto_reject();
      rej_mode = 1'h1;
      rej_cause = CAUSE_TARGET_BUSY;
      an_mgmt_oper = 1'h0;
      an_mgmt_lcc = 16'h0abc;
      an_mgmt_req = 1'h1;
      step();
      an_mgmt_req = 1'h0;
      `CHK("an_tx_lcc", 16'h0abc, an_tx_lcc_q)
      `CHK("an_tx_link", 8'h00, an_tx_link_q)
      `CHK("an_tx_ts", 5'h00, an_tx_ts_q)
      an_rx_os_com = 1'h1;
      step();
      an_rx_os_com = 1'h0;
      `CHK("an_ind_os_com", 1'h1, an_ind_os_com_q)
      `CHK("an_state", an_le_initiated, an_state_q)
      step();
      `CHK("an_tx_reject", 1'h1, an_tx_reject_q)
      `CHK("an_state", an_idle, an_state_q)
      `CHK("an_tx_cause", CAUSE_NOT_POSSIBLE, an_tx_cause_q)
      rej_cause = 8'h07;
      an_rx_com = 1'h1;
      step();
      an_rx_com = 1'h0;
      step();
      `CHK("an_tx_cause", 8'h07, an_tx_cause_q)
      rej_mode = 1'h0;
   endtask

   task automatic t_an_retry();
      an_mgmt_req = 1'h1;
      step();
      an_mgmt_req = 1'h0;
      repeat (REQ_RETRY_CYC) step();
      `CHK("an_tx_req early", 1'h0, an_tx_req_q)
      step();
      `CHK("an_tx_req resend", 1'h1, an_tx_req_q)
      repeat (REQ_RETRY_CYC) step();
      `CHK("an_ind_error early", 1'h0, an_ind_error_q)
      step();
      `CHK("an_ind_error", 1'h1, an_ind_error_q)
      `CHK("an_state", an_idle, an_state_q)
      an_mgmt_req = 1'h1;
      step();
      an_mgmt_req = 1'h0;
      repeat (REQ_RETRY_CYC + TMR_ONE) step();
      `CHK("an_tx_req fresh", 1'h1, an_tx_req_q)
      `CHK("an_ind_error fresh", 1'h0, an_ind_error_q)
      an_rx_cause = 8'h3c;
      an_rx_reject = 1'h1;
      step();
      an_rx_reject = 1'h0;
      `CHK("an_ind_reject", 1'h1, an_ind_reject_q)
      `CHK("an_ind_cause", 8'h3c, an_ind_cause_q)
      `CHK("an_state", an_idle, an_state_q)
      quiet(2100);
   endtask

   task automatic t_le_forced_retry();
      le_mgmt_os_com = 1'h1;
      step();
      le_mgmt_os_com = 1'h0;
      `CHK("le_state", le_initiated, le_state_q)
      le_rx_req = 1'h1;
      step();
      le_rx_req = 1'h0;
      `CHK("le_ind_req", 1'h0, le_ind_req_q)
      `CHK("le_state", le_initiated, le_state_q)
      repeat (FORCED_RETRY_CYC - TMR_ONE) step();
      `CHK("le_tx_os_com early", 1'h0, le_tx_os_com_q)
      step();
      `CHK("le_tx_os_com resend", 1'h1, le_tx_os_com_q)
      repeat (FORCED_RETRY_CYC) step();
      `CHK("le_ind_error early", 1'h0, le_ind_error_q)
      step();
      `CHK("le_ind_error", 1'h1, le_ind_error_q)
      `CHK("le_state", le_idle, le_state_q)
   endtask

   task automatic t_le_forced_reject();
      le_mgmt_os_com = 1'h1;
      step();
      le_mgmt_os_com = 1'h0;
      le_rx_cause = 8'h44;
      le_rx_reject = 1'h1;
      step();
      le_rx_reject = 1'h0;
      `CHK("le_ind_reject", 1'h1, le_ind_reject_q)
      `CHK("le_state", le_idle, le_state_q)
      quiet(2100);
      le_rx_ack = 1'h1;
      step();
      le_rx_ack = 1'h0;
      `CHK("le_ind_ack idle", 1'h1, le_ind_ack_q)
      le_rx_cause = 8'h55;
      le_rx_reject = 1'h1;
      step();
      le_rx_reject = 1'h0;
      `CHK("le_ind_reject idle", 1'h1, le_ind_reject_q)
      `CHK("le_ind_cause", 8'h55, le_ind_cause_q)
      le_mgmt_reject = 1'h1;
      step();
      le_mgmt_reject = 1'h0;
      `CHK("le_tx_reject idle", 1'h0, le_tx_reject_q)
      `CHK("le_state", le_idle, le_state_q)
   endtask

   task automatic t_le_answer();
      le_rx_req = 1'h1;
      step();
      le_rx_req = 1'h0;
      `CHK("le_ind_req", 1'h1, le_ind_req_q)
      `CHK("le_state", le_an_requested, le_state_q)
      le_mgmt_os_com = 1'h1;
      step();
      le_mgmt_os_com = 1'h0;
      `CHK("le_tx_os_com", 1'h0, le_tx_os_com_q)
      le_mgmt_com = 1'h1;
      step();
      le_mgmt_com = 1'h0;
      `CHK("le_tx_com", 1'h1, le_tx_com_q)
      `CHK("le_state", le_initiated, le_state_q)
      // ack held back so the standard timer has to show itself
      repeat (STD_RETRY_CYC) step();
      `CHK("le_tx_com early", 1'h0, le_tx_com_q)
      step();
      `CHK("le_tx_com resend", 1'h1, le_tx_com_q)
      le_rx_ack = 1'h1;
      step();
      le_rx_ack = 1'h0;
      `CHK("le_ind_ack", 1'h1, le_ind_ack_q)
      `CHK("le_state", le_idle, le_state_q)
      quiet(2100);
      le_rx_req = 1'h1;
      step();
      le_rx_req = 1'h0;
      le_mgmt_cause = 8'h21;
      le_mgmt_reject = 1'h1;
      step();
      le_mgmt_reject = 1'h0;
      `CHK("le_tx_reject", 1'h1, le_tx_reject_q)
      `CHK("le_tx_cause", 8'h21, le_tx_cause_q)
   endtask

   // ==========================================================
   // main sequence
   initial begin
      repeat (16) step();
      rst_n = 1'h1;
      step();
      t_an_oper_ack();
      t_an_auto_reject();
      t_an_retry();
      t_le_forced_retry();
      t_le_forced_reject();
      t_le_answer();
      end_sim();
   end
endmodule
